// file: eidf_channel.sv
// One interrupt channel: noise canceller, edge detect, request pulse
`timescale 1ns/10ps
`include "eidf_defines.svh"

module eidf_channel #(
  parameter int NC_COUNT = `EIDF_NC_COUNT
) (
  input  wire logic             clk,        // Gear clock
  input  wire logic             rst,        // Async reset, active high
  input  wire logic             ce,         // Channel clock gated on
  input  wire logic             tick,       // Sampling strobe
  input  wire logic             pin_now,    // Synchronised pin level
  input  wire logic             pin_ok,     // Last two sync stages agree
  input  wire eidf_pkg::eidf_edge_t edge_sel, // Edge select
  output logic                  filt_level, // Filtered level
  output logic                  req         // One-cycle request pulse
);
  localparam int CW = $clog2(NC_COUNT + 1);

  logic [CW-1:0] cnt_reg;   // Agreeing samples seen
  logic [CW-1:0] cnt_next;
  logic          filt_reg;  // Filtered level
  logic          filt_next;
  logic          req_reg;   // Request pulse
  logic          req_next;

  // A sample only counts when the synchroniser is settled
  wire           sample   = tick & pin_ok;
  wire           differs  = pin_now != filt_reg;
  wire           pass     = sample & differs & (cnt_reg == CW'(NC_COUNT - 1));
  // Edge detection looks only at the filtered level
  wire           rising   = pass & pin_now;
  wire           falling  = pass & ~pin_now;
  wire           match    = (edge_sel == `EIDF_EDGE_RISE && rising)
                          | (edge_sel == `EIDF_EDGE_FALL && falling)
                          | (edge_sel == `EIDF_EDGE_BOTH && pass);

  // Counter restarts on any sample that matches the filtered level
  assign cnt_next  = !sample ? cnt_reg : (!differs || pass) ? '0 : cnt_reg + 1'b1;
  assign filt_next = pass ? pin_now : filt_reg;               // [R17]
  assign req_next  = match;                                   // [R01] [R02] [R18]

  // Canceller and detector state; frozen while the channel clock is off
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_reg  <= '0;
      filt_reg <= 1'b0;
      req_reg  <= 1'b0;
    end
    else if (ce)
    begin
      cnt_reg  <= cnt_next;
      filt_reg <= filt_next;
      req_reg  <= req_next;
    end
  end

  assign filt_level = filt_reg;
  assign req        = req_reg;

  // Filtered level moves only after the full run of agreeing samples
  a_filter_run_len: assert property (@(posedge clk) disable iff (rst) // [R17]
    (filt_reg != $past(filt_reg)) |-> ($past(cnt_reg) == CW'(NC_COUNT - 1)))
    else $error("filtered level changed before enough samples");
endmodule : eidf_channel

// file: eidf_defines.svh
// Register indices, field positions, reset values and timing counts
`ifndef EIDF_DEFINES_SVH
`define EIDF_DEFINES_SVH

// Register indices; the byte address is four times the index
`define EIDF_IDX_GATE    12'hF77
`define EIDF_IDX_CTRL1   12'hFD8
`define EIDF_IDX_STATUS  12'hFE0
`define EIDF_IDX_MASK    12'hFE1
`define EIDF_IDX_MODE    12'hFE2

// Channel clock gate register
`define EIDF_GATE_W      6
`define EIDF_GATE_RST    6'h00

// Channel 1 control register fields
`define EIDF_CTRL_RATE_LSB  0
`define EIDF_CTRL_EDGE_LSB  2
`define EIDF_CTRL_LVL_BIT   4
`define EIDF_CTRL_RST       4'h0

// Edge select codes
`define EIDF_EDGE_RISE   2'h0
`define EIDF_EDGE_FALL   2'h1
`define EIDF_EDGE_BOTH   2'h2
`define EIDF_EDGE_RSVD   2'h3

// Sampling rate codes in the high-speed modes
`define EIDF_RATE_DIV1   2'h0
`define EIDF_RATE_DIV4   2'h1
`define EIDF_RATE_DIV8   2'h2
`define EIDF_RATE_DIV16  2'h3

// Low-frequency clock divide for sampling in the low-speed modes
`define EIDF_FS_DIV_LAST 2'h3

// Consecutive agreeing samples before the filter passes a new level
`define EIDF_NC_COUNT    3

// Bus responses
`define EIDF_RESP_OKAY   2'h0
`define EIDF_RESP_SLVERR 2'h2

`endif

// file: eidf_pin_model.sv
// Board-side model of the six external interrupt pins
`timescale 1ns/10ps

module eidf_pin_model (
  input  wire logic       clk,    // Gear clock
  input  wire logic [5:0] level,  // Steady board levels
  input  wire logic [5:0] glitch, // Spike request, one cycle
  output logic      [5:0] pin     // Levels seen at the pins
);
  // Spikes last one cycle, shorter than any filter window
  always_ff @(posedge clk)
  begin
    pin <= level ^ glitch;
  end
endmodule : eidf_pin_model

// file: eidf_pkg.sv
// Shared types of the external interrupt detect and filter block
package eidf_pkg;
  typedef logic [1:0] eidf_edge_t;   // Edge select field
  typedef logic [1:0] eidf_rate_t;   // Sampling rate select field
  typedef logic [5:0] eidf_chan_t;   // One bit per channel
endpackage : eidf_pkg

// file: eidf_top.sv
// External interrupt detect and filter block with AXI4-Lite registers
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/10ps
`include "eidf_defines.svh"

// Contract
// R01: Channel is filter, edge, level, request stages
// R02: Edge detection only sees filtered input
// R03: Six clock enable bits, reset to zero
// R04: Control writes ignored while channel gated
// R05: Software enables channel before configuring it
// R06: Gate register bits 7:6 read zero
// R07: Software masks interrupt before toggling gate
// R08: Software masks interrupt before mode change
// R09: Wait twelve slow clocks, then clear latch
// R10: Wait gear and sample clocks, then clear
// R11: Software masks interrupt before control rewrite
// R12: Edge codes: rise, fall, both, reserved
// R13: Sample rate divides gear or slow clock
// R14: Level bit captures filtered level on request
// R15: Control bits 7:5 read zero, reset zero
// R16: Latch holds until accepted or cleared
// R17: Filter passes level after several equal samples
// R18: Selected edge gives one-cycle request pulse
module eidf_top #(
  parameter int NC_COUNT = `EIDF_NC_COUNT // Samples the filter needs
) (
  input  wire logic        clk,           // Gear clock, 200 MHz
  input  wire logic        rst,           // Async reset, active high
  input  wire logic        ce,            // Clock enable, freezes all
  input  wire logic [5:0]  ext_irq_pin,   // External interrupt pins
  input  wire logic        low_freq_clock, // Low-frequency clock, sampled
  input  wire logic [5:0]  cpu_accept,    // CPU accepted channel request
  output logic [5:0]       irq_req,       // Per-channel request pulses
  output logic [5:0]       irq_latch,     // Per-channel interrupt latches
  output logic             irq,           // Level interrupt, unmasked latch
  input  wire logic [15:0] s_axi_awaddr,  // Write address
  input  wire logic        s_axi_awvalid, // Write address valid
  output logic             s_axi_awready, // Write address ready
  input  wire logic [31:0] s_axi_wdata,   // Write data
  input  wire logic [3:0]  s_axi_wstrb,   // Write strobes
  input  wire logic        s_axi_wvalid,  // Write data valid
  output logic             s_axi_wready,  // Write data ready
  output logic [1:0]       s_axi_bresp,   // Write response
  output logic             s_axi_bvalid,  // Write response valid
  input  wire logic        s_axi_bready,  // Write response ready
  input  wire logic [15:0] s_axi_araddr,  // Read address
  input  wire logic        s_axi_arvalid, // Read address valid
  output logic             s_axi_arready, // Read address ready
  output logic [31:0]      s_axi_rdata,   // Read data
  output logic [1:0]       s_axi_rresp,   // Read response
  output logic             s_axi_rvalid,  // Read data valid
  input  wire logic        s_axi_rready   // Read data ready
);

  // Word decode of a byte address against a register index
  function automatic logic eidf_hit(input logic [15:0] addr, input logic [11:0] idx);
    eidf_hit = (addr[15:14] == 2'h0) && (addr[13:2] == idx);
  endfunction : eidf_hit

  // Sampling strobe for one channel from its rate code and the mode
  function automatic logic eidf_tick(input eidf_pkg::eidf_rate_t code,
                                     input logic [3:0] div, input logic slow,
                                     input logic fs4);
    if (slow)
      eidf_tick = fs4;
    else
    begin
      case (code)
        `EIDF_RATE_DIV1: eidf_tick = 1'b1;
        `EIDF_RATE_DIV4: eidf_tick = (div[1:0] == 2'h3);
        `EIDF_RATE_DIV8: eidf_tick = (div[2:0] == 3'h7);
        default:         eidf_tick = (div == 4'hF);
      endcase
    end
  endfunction : eidf_tick

  // Register state
  eidf_pkg::eidf_chan_t gate_reg;      // Channel clock enables
  logic [3:0]           ctrl_reg;      // Channel 1 edge and rate fields
  logic                 lvl_reg;       // Channel 1 filtered level at request
  eidf_pkg::eidf_chan_t latch_reg;     // Interrupt latches, sticky
  eidf_pkg::eidf_chan_t latch_next;
  eidf_pkg::eidf_chan_t mask_reg;      // Interrupt mask, 1 enables
  logic                 slow_reg;      // 1 selects the low-speed modes

  // Bus state
  logic        aw_held_reg;           // Write address captured
  logic [15:0] aw_addr_reg;
  logic        w_held_reg;            // Write data captured
  logic [31:0] w_data_reg;
  logic        w_lane0_reg;           // Byte lane 0 strobed
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_reg;
  logic        rd_gate_reg;           // Last read hit the gate register
  logic        rd_ctrl_reg;           // Last read hit channel 1 control

  // Synchronisers and dividers
  logic [5:0]  pin_s1_reg;            // First stage, read only by second
  logic [5:0]  pin_s2_reg;
  logic [5:0]  pin_s3_reg;
  logic        fs_s1_reg;
  logic        fs_s2_reg;
  logic        fs_s3_reg;
  logic        fs_level_reg;          // Settled slow clock level
  logic [1:0]  fs_cnt_reg;            // Divides slow clock by four
  logic [3:0]  div_reg;               // Gear clock prescaler

  // Channel wires
  eidf_pkg::eidf_chan_t filt;         // Filtered levels
  eidf_pkg::eidf_chan_t req;          // Request pulses
  eidf_pkg::eidf_chan_t tick;         // Sampling strobes
  eidf_pkg::eidf_edge_t ch_edge [6];  // Edge select per channel
  eidf_pkg::eidf_rate_t ch_rate [6];  // Rate select per channel

  // Bus decode
  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire ar_take  = s_axi_arvalid & s_axi_arready;
  wire wr_fire  = aw_held_reg & w_held_reg & ~bvalid_reg;
  wire wr_gate  = eidf_hit(aw_addr_reg, `EIDF_IDX_GATE);
  wire wr_ctrl  = eidf_hit(aw_addr_reg, `EIDF_IDX_CTRL1);
  wire wr_stat  = eidf_hit(aw_addr_reg, `EIDF_IDX_STATUS);
  wire wr_mask  = eidf_hit(aw_addr_reg, `EIDF_IDX_MASK);
  wire wr_mode  = eidf_hit(aw_addr_reg, `EIDF_IDX_MODE);
  wire wr_map   = wr_gate | wr_ctrl | wr_stat | wr_mask | wr_mode;
  wire wr_en    = wr_fire & w_lane0_reg;
  wire rd_gate  = eidf_hit(s_axi_araddr, `EIDF_IDX_GATE);
  wire rd_ctrl  = eidf_hit(s_axi_araddr, `EIDF_IDX_CTRL1);
  wire rd_stat  = eidf_hit(s_axi_araddr, `EIDF_IDX_STATUS);
  wire rd_mask  = eidf_hit(s_axi_araddr, `EIDF_IDX_MASK);
  wire rd_mode  = eidf_hit(s_axi_araddr, `EIDF_IDX_MODE);
  wire rd_map   = rd_gate | rd_ctrl | rd_stat | rd_mask | rd_mode;
  // Reading the latch register clears what it returned
  wire stat_clr = ar_take & rd_stat;

  // Read multiplexer; unused upper bits return zero
  wire [31:0] rd_mux = rd_gate ? {26'h0, gate_reg}                  // [R06]
                     : rd_ctrl ? {27'h0, lvl_reg, ctrl_reg}          // [R15]
                     : rd_stat ? {26'h0, latch_reg}
                     : rd_mask ? {26'h0, mask_reg}
                     : rd_mode ? {31'h0, slow_reg}
                     : 32'h0;

  // Handshakes drop while frozen so no beat is lost
  assign s_axi_awready = ce & ~aw_held_reg & ~bvalid_reg;
  assign s_axi_wready  = ce & ~w_held_reg & ~bvalid_reg;
  assign s_axi_arready = ce & ~rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  // Write channel capture and response
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 16'h0000;
      w_held_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_lane0_reg <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `EIDF_RESP_OKAY;
    end
    else if (ce)
    begin
      if (aw_take)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_held_reg  <= 1'b1;
        w_data_reg  <= s_axi_wdata;
        w_lane0_reg <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_map ? `EIDF_RESP_OKAY : `EIDF_RESP_SLVERR;
      end
      else if (bvalid_reg && s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // Read channel; data registered at the address beat
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rvalid_reg  <= 1'b0;
      rresp_reg   <= `EIDF_RESP_OKAY;
      rdata_reg   <= 32'h0000_0000;
      rd_gate_reg <= 1'b0;
      rd_ctrl_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (ar_take)
      begin
        rvalid_reg  <= 1'b1;
        rresp_reg   <= rd_map ? `EIDF_RESP_OKAY : `EIDF_RESP_SLVERR;
        rdata_reg   <= rd_mux;
        rd_gate_reg <= rd_gate;
        rd_ctrl_reg <= rd_ctrl;
      end
      else if (s_axi_rready)
        rvalid_reg <= 1'b0;
    end
  end

  // Control registers written by software
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      gate_reg <= `EIDF_GATE_RST;                               // [R03]
      mask_reg <= 6'h00;
      slow_reg <= 1'b0;
    end
    else if (ce && wr_en)
    begin
      if (wr_gate)
        gate_reg <= w_data_reg[5:0];                            // [R03]
      if (wr_mask)
        mask_reg <= w_data_reg[5:0];
      if (wr_mode)
        slow_reg <= w_data_reg[0];
    end
  end

  // Channel 1 control; dropped while its clock is gated off
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg <= `EIDF_CTRL_RST;                               // [R15]
      lvl_reg  <= 1'b0;
    end
    else if (ce)
    begin
      if (!gate_reg[1])
      begin
        ctrl_reg <= `EIDF_CTRL_RST;                             // [R04]
        lvl_reg  <= 1'b0;
      end
      else
      begin
        if (wr_en && wr_ctrl)
          ctrl_reg <= w_data_reg[3:0];
        if (req[1])
          lvl_reg <= filt[1];                                   // [R14]
      end
    end
  end

  // Latch: a new request beats a same-cycle clear or acceptance
  assign latch_next = (latch_reg & ~(stat_clr ? latch_reg : 6'h00) & ~cpu_accept) | req; // [R16]

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      latch_reg <= 6'h00;
    else if (ce)
      latch_reg <= latch_next;                                  // [R16]
  end

  assign irq_latch = latch_reg;
  assign irq_req   = req;
  assign irq       = |(latch_reg & mask_reg);

  // Pin and slow-clock synchronisers, three stages each
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_s1_reg <= 6'h00;
      pin_s2_reg <= 6'h00;
      pin_s3_reg <= 6'h00;
      fs_s1_reg  <= 1'b0;
      fs_s2_reg  <= 1'b0;
      fs_s3_reg  <= 1'b0;
    end
    else if (ce)
    begin
      pin_s1_reg <= ext_irq_pin;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      fs_s1_reg  <= low_freq_clock;
      fs_s2_reg  <= fs_s1_reg;
      fs_s3_reg  <= fs_s2_reg;
    end
  end

  // A slow clock edge counts once stages two and three agree
  wire fs_agree = fs_s2_reg == fs_s3_reg;
  wire fs_rise  = fs_agree & fs_s3_reg & ~fs_level_reg;
  wire fs4_tick = fs_rise & (fs_cnt_reg == `EIDF_FS_DIV_LAST);

  // Prescalers for the sampling strobes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      fs_level_reg <= 1'b0;
      fs_cnt_reg   <= 2'h0;
      div_reg      <= 4'h0;
    end
    else if (ce)
    begin
      if (fs_agree)
        fs_level_reg <= fs_s3_reg;
      if (fs_rise)
        fs_cnt_reg <= fs_cnt_reg + 2'h1;
      div_reg <= div_reg + 4'h1;
    end
  end

  // Six channels; only channel 1 has a control register here
  generate
    for (genvar i = 0; i < 6; i++)
    begin : g_chan
      if (i == 1)
      begin : g_cfg
        assign ch_edge[i] = ctrl_reg[3:2];                      // [R12]
        assign ch_rate[i] = ctrl_reg[1:0];
      end
      else
      begin : g_fix
        assign ch_edge[i] = `EIDF_EDGE_RISE;
        assign ch_rate[i] = `EIDF_RATE_DIV1;
      end
      assign tick[i] = eidf_tick(ch_rate[i], div_reg, slow_reg, fs4_tick); // [R13]
      eidf_channel #(
        .NC_COUNT (NC_COUNT)
      ) u_chan (
        .clk        (clk),
        .rst        (rst),
        .ce         (ce & gate_reg[i]),                         // [R03]
        .tick       (tick[i]),
        .pin_now    (pin_s3_reg[i]),
        .pin_ok     (pin_s2_reg[i] == pin_s3_reg[i]),
        .edge_sel   (ch_edge[i]),
        .filt_level (filt[i]),
        .req        (req[i])                                    // [R01]
      );
    end
  endgenerate

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_div4_tick;
    tick[1] && ce && !slow_reg && ctrl_reg[1:0] == `EIDF_RATE_DIV4;
  endsequence

  a_gate_hi_zero: assert property (rvalid_reg && rd_gate_reg |-> rdata_reg[31:6] == 26'h0) // [R06]
    else $error("gate register upper bits not zero");
  a_ctrl_hi_zero: assert property (rvalid_reg && rd_ctrl_reg |-> rdata_reg[31:5] == 27'h0) // [R15]
    else $error("control register upper bits not zero");
  a_ctrl_gated_drop: assert property (ce && !gate_reg[1] |=> ctrl_reg == 4'h0) // [R04]
    else $error("control kept while channel gated");
  a_req_one_cycle: assert property (ce && req[1] |=> !req[1]) // [R18]
    else $error("request pulse longer than one cycle");
  a_edge_rise: assert property ( // [R12]
    $rose(filt[1]) && $past(ctrl_reg[3:2]) == `EIDF_EDGE_RISE |-> req[1])
    else $error("rising edge gave no request");
  a_edge_fall_only: assert property ( // [R12]
    $rose(filt[1]) && $past(ctrl_reg[3:2]) == `EIDF_EDGE_FALL |-> !req[1])
    else $error("falling select fired on rising edge");
  a_edge_rsvd: assert property ( // [R12]
    $past(ctrl_reg[3:2]) == `EIDF_EDGE_RSVD && $past(ce) |-> !req[1])
    else $error("reserved edge code raised a request");
  a_filt_first: assert property (req[1] |-> filt[1] != $past(filt[1])) // [R02]
    else $error("request without filtered edge");
  a_lvl_capture: assert property ( // [R14]
    ce && req[1] && gate_reg[1] |=> lvl_reg == $past(filt[1]))
    else $error("level bit not captured on request");
  a_latch_hold: assert property ( // [R16]
    latch_reg[1] && !(ce && (cpu_accept[1] || stat_clr)) |=> latch_reg[1])
    else $error("latch dropped without clear");
  a_div4_gap: assert property ( // [R13]
    s_div4_tick |=> (!tick[1] || ctrl_reg[1:0] != `EIDF_RATE_DIV4)[*3])
    else $error("divide by four strobe too fast");
endmodule : eidf_top

// file: external_irq_detect_filter_tb.sv
// Self-checking bench for the external interrupt detect and filter block
`timescale 1ns/10ps
`include "eidf_defines.svh"

`define TB_CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
  $display("CHECK FAILED at %0t got %h expected %h", $time, (got), (exp)); end end

module external_irq_detect_filter_tb;
  localparam int NC = 2;        // Short filter window keeps the run brief
  localparam int LF_HALF = 20;  // Half period of the slow clock, gear cycles
  logic        clk;             // Gear clock
  logic        rst;             // Reset
  logic        lfc = 1'b0;      // Low-frequency clock, runs free
  logic [5:0]  lf_cnt = 6'h00;  // Slow clock divider
  logic [5:0]  lvl, glt, pins;  // Board levels, spikes, pins
  logic [5:0]  acc, req, latch; // Accepts, requests, latches
  logic        irq;             // Level interrupt
  logic [15:0] awa, ara;        // Bus addresses
  logic        awv, awr, wv;    // Write address and data handshake
  logic        wr_rdy, bv, brd; // Write data ready, response handshake
  logic        arv, arr, rv;    // Read handshake
  logic        rrd;             // Read ready
  logic [31:0] wdat, rdat;      // Bus data
  logic [3:0]  wstb;            // Write strobes
  logic [1:0]  bresp, rresp;    // Bus responses
  int          bad_count;       // Mismatches
  int          checks_done;     // Comparisons
  logic [31:0] seed;            // Random state
  logic [31:0] d;               // Read data
  logic [1:0]  r, c;            // Response, edge code
  logic [5:0]  ov, nv, ex, tot; // Old, new, expected, accumulated
  logic        lv1;             // Expected captured level
  logic [7:0]  cnt [6];         // High cycles of each request
  int          lat;             // Measured latency
  logic        ce_in = 1'b1;    // Clock enable

  eidf_pin_model board (.clk(clk), .level(lvl), .glitch(glt), .pin(pins));

  eidf_top #(.NC_COUNT(NC)) dut (
    .clk(clk), .rst(rst), .ce(ce_in), .ext_irq_pin(pins), .low_freq_clock(lfc),
    .cpu_accept(acc), .irq_req(req), .irq_latch(latch), .irq(irq),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdat),
    .s_axi_wstrb(wstb), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rrd));

  // Gear clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Slow clock, unrelated to any transfer
  always @(posedge clk)
  begin
    lf_cnt <= (lf_cnt == 6'(LF_HALF - 1)) ? 6'h00 : lf_cnt + 6'h01;
    if (lf_cnt == 6'(LF_HALF - 1))
      lfc <= ~lfc;
  end

  // Verdict and end of run
  task automatic complete_run();
    if (bad_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  // A wait that ran out counts as a mismatch
  task automatic give_up();
    bad_count++;
    complete_run();
  endtask : give_up

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  // Expected channel 1 request for an edge code and a level change
  function automatic logic exp_req1(input logic [1:0] code, input logic o, input logic n);
    case (code)
      `EIDF_EDGE_RISE: return ~o & n;
      `EIDF_EDGE_FALL: return o & ~n;
      `EIDF_EDGE_BOTH: return o ^ n;
      default:         return 1'b0;
    endcase
  endfunction : exp_req1

  // Latency window: sync and model delay, then NC samples at period dv
  function automatic logic lat_ok(input int l, input int dv);
    return l >= (NC - 1) * dv + 3 && l <= NC * dv + dv / 4 + 8;
  endfunction : lat_ok

  // Bus write; address and data offered together, each dropped once taken
  task automatic wr(input logic [11:0] idx, input logic [7:0] dat, output logic [1:0] resp);
    int n;
    awa <= {2'h0, idx, 2'h0};
    wdat <= {24'h0, dat};
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    for (n = 0; n < 200; n++)
    begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
      if (bv) break;
    end
    resp = bresp;
    if (n == 200) give_up();
  endtask : wr

  // Bus read
  task automatic rd(input logic [11:0] idx, output logic [31:0] dat, output logic [1:0] resp);
    int n;
    ara <= {2'h0, idx, 2'h0};
    arv <= 1'b1;
    rrd <= 1'b1;
    for (n = 0; n < 200; n++)
    begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    dat = rdat;
    resp = rresp;
    if (n == 200) give_up();
  endtask : rd

  // Toggle pin 1 and count cycles to its request
  task automatic measure(output int l);
    lvl[1] <= ~lvl[1];
    for (l = 0; l < 1000; l++)
    begin
      @(posedge clk);
      if (req[1] === 1'b1) break;
    end
    if (l == 1000) give_up();
  endtask : measure

  // Main sequence
  initial
  begin
    {lvl, glt, acc, awv, wv, brd, arv, rrd} = '0;
    {awa, ara, wdat} = '0;
    wstb = 4'hF;
    bad_count = 0;
    checks_done = 0;
    seed = 32'h22;
    rst = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    // Reset values, then a control write while the channel is gated off
    rd(`EIDF_IDX_GATE, d, r); `TB_CHK(d, 32'h0)
    rd(`EIDF_IDX_CTRL1, d, r); `TB_CHK(d, 32'h0)
    wr(`EIDF_IDX_CTRL1, 8'h0A, r);
    rd(`EIDF_IDX_CTRL1, d, r); `TB_CHK(d, 32'h0)
    wr(`EIDF_IDX_GATE, 8'hFF, r); `TB_CHK(r, `EIDF_RESP_OKAY)
    rd(`EIDF_IDX_GATE, d, r); `TB_CHK(d, 32'h3F)
    `TB_CHK(r, `EIDF_RESP_OKAY)
    wr(`EIDF_IDX_CTRL1, 8'hFF, r);
    rd(`EIDF_IDX_CTRL1, d, r); `TB_CHK(d, 32'h0F)
    rd(12'h100, d, r); `TB_CHK(r, `EIDF_RESP_SLVERR)
    `TB_CHK(d, 32'h0)
    wr(12'h100, 8'h55, r); `TB_CHK(r, `EIDF_RESP_SLVERR)
    // Each sampling rate with both edges, pin 1 toggled
    wr(`EIDF_IDX_MASK, 8'h00, r);
    for (int i = 0; i < 4; i++)
    begin
      wr(`EIDF_IDX_CTRL1, {6'h02, 2'(i)}, r);
      repeat (40) @(posedge clk);
      measure(lat); `TB_CHK(lat_ok(lat, 1 << (i == 0 ? 0 : i + 1)), 1'b1)
    end
    // Low-speed sampling: slow clock over four
    wr(`EIDF_IDX_MODE, 8'h01, r);
    repeat (12 * 2 * LF_HALF) @(posedge clk);
    rd(`EIDF_IDX_STATUS, d, r);
    measure(lat); `TB_CHK(lat_ok(lat, 4 * 2 * LF_HALF), 1'b1)
    wr(`EIDF_IDX_MODE, 8'h00, r);
    repeat (2 + 3 * 16) @(posedge clk);
    wr(`EIDF_IDX_CTRL1, 8'h08, r);
    repeat (40) @(posedge clk);
    rd(`EIDF_IDX_STATUS, d, r);
    // One-cycle spikes on every pin never pass the filter
    glt <= 6'h3F;
    @(posedge clk);
    glt <= 6'h00;
    repeat (30)
    begin
      @(posedge clk);
      `TB_CHK(req, 6'h00)
    end
    // Random pin changes; channel 1 walks every edge code first
    ov = lvl;
    lv1 = lvl[1];
    tot = 6'h00;
    for (int i = 0; i < 14; i++)
    begin
      seed = xs(seed);
      c = (i < 4) ? 2'(i) : seed[9:8];
      nv = seed[5:0];
      wr(`EIDF_IDX_CTRL1, {4'h0, c, 2'h0}, r);
      lvl <= nv;
      cnt = '{default: 8'h00};
      repeat (24)
      begin
        @(posedge clk);
        foreach (cnt[k]) cnt[k] += {7'h0, req[k]};
      end
      ex = {nv[5:2] & ~ov[5:2], exp_req1(c, ov[1], nv[1]), nv[0] & ~ov[0]};
      foreach (cnt[k]) `TB_CHK(cnt[k], {7'h0, ex[k]})
      lv1 = ex[1] ? nv[1] : lv1;
      rd(`EIDF_IDX_CTRL1, d, r); `TB_CHK(d, {27'h0, lv1, c, 2'h0})
      tot |= ex;
      ov = nv;
    end
    // Latches hold while masked, the CPU accept clears them
    `TB_CHK(irq, 1'b0)
    `TB_CHK(latch, tot)
    wr(`EIDF_IDX_MASK, 8'h3F, r);
    `TB_CHK(irq, |tot)
    acc <= tot;
    @(posedge clk);
    acc <= 6'h00;
    @(posedge clk);
    `TB_CHK(latch, 6'h00)
    `TB_CHK(irq, 1'b0)
    // Raise channel 1, mask it, then clear it by a status read
    wr(`EIDF_IDX_CTRL1, 8'h08, r);
    measure(lat);
    repeat (30) @(posedge clk);
    `TB_CHK(irq, 1'b1)
    wr(`EIDF_IDX_MASK, 8'h00, r);
    `TB_CHK(irq, 1'b0)
    rd(`EIDF_IDX_STATUS, d, r); `TB_CHK(d, 32'h2)
    rd(`EIDF_IDX_STATUS, d, r); `TB_CHK(d, 32'h0)
    // Clock enable low freezes the filter, latches and bus readies
    ce_in <= 1'b0;
    lvl[1] <= ~lvl[1];
    repeat (20)
    begin
      @(posedge clk);
      `TB_CHK({req, latch, arr, awr, wr_rdy}, 15'h0000)
    end
    ce_in <= 1'b1;
    cnt[1] = 8'h00;
    repeat (30)
    begin
      @(posedge clk);
      cnt[1] += {7'h0, req[1]};
    end
    `TB_CHK(cnt[1], 8'h01)
    `TB_CHK(latch, 6'h02)
    complete_run();
  end
endmodule : external_irq_detect_filter_tb
